// file: common/rtdspi_cfg.svh
// constants of the serial register port: offsets, fields, reset values
`ifndef RTDSPI_CFG_SVH
`define RTDSPI_CFG_SVH

// register indexes (read address = index, write address = index + 80h)
`define RTDSPI_IDX_CFG    7'h00
`define RTDSPI_IDX_DAT_H  7'h01
`define RTDSPI_IDX_DAT_L  7'h02
`define RTDSPI_IDX_UTH_H  7'h03
`define RTDSPI_IDX_UTH_L  7'h04
`define RTDSPI_IDX_LTH_H  7'h05
`define RTDSPI_IDX_LTH_L  7'h06
`define RTDSPI_IDX_FLT    7'h07
`define RTDSPI_NUM_REGS   7'h08

// answer to an unmapped read
`define RTDSPI_UNMAPPED   8'hff

// reset values
`define RTDSPI_CFG_RST    8'h00
`define RTDSPI_UTH_RST    16'hffff
`define RTDSPI_LTH_RST    16'h0000

// configuration register fields
`define RTDSPI_CFG_ONESHOT 5
`define RTDSPI_CFG_CYC_HI  3
`define RTDSPI_CFG_CYC_LO  2
`define RTDSPI_CFG_CLR     1

// latched flag positions inside the six-bit flag field
`define RTDSPI_FLG_HIGH   5
`define RTDSPI_FLG_LOW    4

// serial framing
`define RTDSPI_DIR_BIT    7
`define RTDSPI_LAST_BIT   3'h7

`endif

// file: common/rtdspi_if.sv
// carrier between the register file and the serial link engine
`timescale 1ns/10ps
`default_nettype none
interface rtdspi_if;
  logic [63:0] image;     // frozen register image, byte i at bits 8i+7:8i
  logic        wr_toggle; // flips once per written data byte
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;

  modport regs (
    output image,
    input  wr_toggle,
    input  wr_addr,
    input  wr_data
  );

  modport link (
    input  image,
    output wr_toggle,
    output wr_addr,
    output wr_data
  );
endinterface : rtdspi_if
`default_nettype wire

// file: common/rtdspi_pkg.sv
// types of the serial register port
`default_nettype none
package rtdspi_pkg;

  // link frame phases
  typedef enum logic [2:0] {
    RTDSPI_ST_ADDR = 3'b001,
    RTDSPI_ST_RD   = 3'b010,
    RTDSPI_ST_WR   = 3'b100
  } rtdspi_state_t;

  // link frame state, cleared whenever chip select is high
  typedef struct packed {
    rtdspi_state_t state;
    logic [2:0]    bitcnt;
    logic [6:0]    shift;
    logic [7:0]    addr;
    logic [7:0]    tx;
  } rtdspi_link_t;

  // write mailbox towards the system clock
  typedef struct packed {
    logic       toggle;
    logic [7:0] addr;
    logic [7:0] data;
  } rtdspi_mbox_t;

  // system clock state
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_seen;
    logic [7:0]  cfg;
    logic [14:0] data;
    logic [15:0] uth;
    logic [15:0] lth;
    logic [5:0]  flags;
    logic [63:0] image;
  } rtdspi_sys_t;

endpackage : rtdspi_pkg
`default_nettype wire

// file: hw/rtdspi_link.sv
// serial link engine clocked by the master's serial clock
`timescale 1ns/10ps
`default_nettype none
`include "rtdspi_cfg.svh"
module rtdspi_link (
  // serial pins
  input  wire logic serial_clk,
  input  wire logic chip_sel_n,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_en,
  // global reset
  input  wire logic reset,
  // register side
  rtdspi_if.link    regs
);

  logic                     pol_q;
  logic                     lclk;
  logic                     frame_rst;
  logic [7:0]               rx_byte;
  logic                     out_q;
  logic                     oe_q;
  logic                     armed_q;
  rtdspi_pkg::rtdspi_link_t ln_q;
  rtdspi_pkg::rtdspi_link_t ln_d;
  rtdspi_pkg::rtdspi_mbox_t mb_q;
  rtdspi_pkg::rtdspi_mbox_t mb_d;

  // read mux over the frozen image
  function automatic logic [7:0] reg_read(input logic [7:0]  a,
                                          input logic [63:0] img);
    logic [7:0] r;
    r = `RTDSPI_UNMAPPED;
    if (a[6:0] < `RTDSPI_NUM_REGS) begin
      r = img[{a[2:0], 3'h0} +: 8];
    end
    return r;
  endfunction : reg_read

  // address step with wrap inside each half
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    return {a[7], a[6:0] + 7'h01};
  endfunction : next_addr

  // ****************************************
  // polarity and internal clock
  // ****************************************

  always_ff @(negedge chip_sel_n or posedge reset) begin
    if (reset) begin
      pol_q <= 1'b0;
    end else begin
      pol_q <= serial_clk;
    end
  end

  assign lclk      = ~(serial_clk ^ pol_q);
  assign frame_rst = chip_sel_n | reset;
  assign rx_byte   = {ln_q.shift, serial_in};

  // polarity step ignored
  // a polarity change between frames lifts lclk as select falls;
  // capture is only armed by the first leading edge of the frame
  always_ff @(negedge lclk or posedge frame_rst) begin
    if (frame_rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  // ****************************************
  // frame sequencing
  // ****************************************

  // next frame and mailbox state
  always_comb begin
    ln_d        = ln_q;
    mb_d        = mb_q;
    ln_d.shift  = rx_byte[6:0];
    ln_d.bitcnt = ln_q.bitcnt + 3'h1;
    ln_d.tx     = {ln_q.tx[6:0], 1'b1};
    if (ln_q.bitcnt == `RTDSPI_LAST_BIT) begin
      case (ln_q.state)
        rtdspi_pkg::RTDSPI_ST_ADDR: begin
          ln_d.addr = rx_byte;
          if (rx_byte[`RTDSPI_DIR_BIT]) begin
            ln_d.state = rtdspi_pkg::RTDSPI_ST_WR;
          end else begin
            ln_d.state = rtdspi_pkg::RTDSPI_ST_RD;
            ln_d.tx    = reg_read(rx_byte, regs.image);
          end
        end
        rtdspi_pkg::RTDSPI_ST_RD: begin
          ln_d.addr = next_addr(ln_q.addr);
          ln_d.tx   = reg_read(next_addr(ln_q.addr), regs.image);
        end
        rtdspi_pkg::RTDSPI_ST_WR: begin
          mb_d.addr   = ln_q.addr;
          mb_d.data   = rx_byte;
          mb_d.toggle = ~mb_q.toggle;
          ln_d.addr   = next_addr(ln_q.addr);
        end
        default: begin
          ln_d.state = rtdspi_pkg::RTDSPI_ST_ADDR;
        end
      endcase
    end
    // hold everything until the frame is armed
    if (!armed_q) begin
      ln_d = ln_q;
      mb_d = mb_q;
    end
  end

  // frame registers, cleared while chip select is high
  always_ff @(posedge lclk or posedge frame_rst) begin
    if (frame_rst) begin
      ln_q <= '{state: rtdspi_pkg::RTDSPI_ST_ADDR, default: '0};
    end else begin
      ln_q <= ln_d;
    end
  end

  // mailbox survives the end of a frame
  always_ff @(posedge lclk or posedge reset) begin
    if (reset) begin
      mb_q <= '0;
    end else begin
      mb_q <= mb_d;
    end
  end

  // ****************************************
  // output driver
  // ****************************************

  // enable only once a read byte is loaded
  always_ff @(negedge lclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      out_q <= ln_q.tx[7];
      oe_q  <= (ln_q.state == rtdspi_pkg::RTDSPI_ST_RD);
    end
  end

  assign serial_out     = oe_q & out_q;
  assign serial_out_en  = oe_q;
  assign regs.wr_toggle = mb_q.toggle;
  assign regs.wr_addr   = mb_q.addr;
  assign regs.wr_data   = mb_q.data;

endmodule : rtdspi_link
`default_nettype wire

// file: hw/rtdspi_top.sv
// serial register port with ratio data, trip thresholds and fault flags
`timescale 1ns/10ps
`default_nettype none
`include "rtdspi_cfg.svh"
module rtdspi_top (
  // system clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // serial pins
  input  wire logic        serial_clk,
  input  wire logic        chip_sel_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en,
  // converter side
  input  wire logic [14:0] conv_code,
  input  wire logic        conv_valid,
  input  wire logic [3:0]  fault_in,
  output logic [7:0]       config_value,
  output logic [7:0]       fault_status
);

  rtdspi_pkg::rtdspi_sys_t s_q;
  rtdspi_pkg::rtdspi_sys_t s_d;
  logic                    wr_go;
  logic                    clr;
  logic [6:0]              widx;
  logic [5:0]              set;
  logic                    any_fault;

  rtdspi_if bus ();

  // ****************************************
  // link engine on the serial clock
  // ****************************************

  rtdspi_link u_link (
    .serial_clk    (serial_clk),
    .chip_sel_n    (chip_sel_n),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_en (serial_out_en),
    .reset         (reset),
    .regs          (bus.link)
  );

  // ****************************************
  // register file on the system clock
  // ****************************************

  assign widx      = bus.wr_addr[6:0];
  assign wr_go     = s_q.tg_s2 ^ s_q.tg_seen;
  assign any_fault = |s_q.flags;

  // next state of registers, flags and image
  always_comb begin
    s_d         = s_q;
    clr         = 1'b0;
    s_d.cs_s1   = chip_sel_n;
    s_d.cs_s2   = s_q.cs_s1;
    s_d.tg_s1   = bus.wr_toggle;
    s_d.tg_s2   = s_q.tg_s1;
    s_d.tg_seen = s_q.tg_s2;
    if (wr_go) begin
      if (widx == `RTDSPI_IDX_CFG) begin
        s_d.cfg = bus.wr_data;
        s_d.cfg[`RTDSPI_CFG_CLR] = 1'b0;
        clr = bus.wr_data[`RTDSPI_CFG_CLR]
              & ~bus.wr_data[`RTDSPI_CFG_ONESHOT]
              & ~bus.wr_data[`RTDSPI_CFG_CYC_HI]
              & ~bus.wr_data[`RTDSPI_CFG_CYC_LO];
      end else if (widx == `RTDSPI_IDX_UTH_H) begin
        s_d.uth[15:8] = bus.wr_data;
      end else if (widx == `RTDSPI_IDX_UTH_L) begin
        s_d.uth[7:0] = bus.wr_data;
      end else if (widx == `RTDSPI_IDX_LTH_H) begin
        s_d.lth[15:8] = bus.wr_data;
      end else if (widx == `RTDSPI_IDX_LTH_L) begin
        s_d.lth[7:0] = bus.wr_data;
      end else begin
        clr = 1'b0;
      end
    end
    if (conv_valid) begin
      s_d.data = conv_code;
    end
    set = {2'b00, fault_in};
    set[`RTDSPI_FLG_HIGH] = conv_valid & (conv_code >= s_q.uth[15:1]);
    set[`RTDSPI_FLG_LOW]  = conv_valid & (conv_code <= s_q.lth[15:1]);
    s_d.flags = (clr ? 6'h00 : s_q.flags) | set;
    // image refreshed only while no frame is running
    if (s_q.cs_s2) begin
      // status bits 7 to 2, low bits zero
      s_d.image = {s_q.flags, 2'b00,
                   s_q.lth[7:0], s_q.lth[15:8],
                   s_q.uth[7:0], s_q.uth[15:8],
                   s_q.data[6:0], any_fault,
                   s_q.data[14:7],
                   s_q.cfg};
    end
  end

  // system clock registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '{cs_s1: 1'b1, cs_s2: 1'b1,
               cfg: `RTDSPI_CFG_RST,
               uth: `RTDSPI_UTH_RST,
               lth: `RTDSPI_LTH_RST,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.image    = s_q.image;
  assign config_value = s_q.cfg;
  assign fault_status = {s_q.flags, 2'b00};

endmodule : rtdspi_top
`default_nettype wire

// file: tb/rtdspi_master.sv
// behavioural spi master model driving the serial pins
`timescale 1ns/10ps
`default_nettype none
module rtdspi_master (
  // serial pins
  output var logic serial_clk,
  output var logic chip_sel_n,
  output var logic serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  logic cpol_q;

  // clock and data idle at time zero, select driven low until the first deselect
  initial begin
    cpol_q     = 1'b0;
    serial_clk = 1'b0;
    chip_sel_n = 1'b0;
    serial_in  = 1'b0;
    // one clean deselect edge clears the frame state
    #1 chip_sel_n = 1'b1;
  end

  task automatic start(input logic cpol);
    cpol_q     = cpol;
    serial_clk = cpol;
    #20 chip_sel_n = 1'b0;
    #250;
  endtask : start

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_clk = ~cpol_q;
      serial_in  = tx[i];
      #15 serial_clk = cpol_q;
      rx[i] = serial_out;
      #15;
    end
    serial_in = ~tx[0]; // no stale data between bytes
  endtask : xbyte

  task automatic stop;
    #15 chip_sel_n = 1'b1;
    #500;
  endtask : stop
endmodule : rtdspi_master
`default_nettype wire

// file: tb/rtdspi_top_props.sv
// assertions on the pins of the serial register port
`timescale 1ns/10ps
`default_nettype none
module rtdspi_top_props (
  // clocks and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        serial_clk,
  // serial pins
  input wire logic        chip_sel_n,
  input wire logic        serial_in,
  input wire logic        serial_out,
  input wire logic        serial_out_en,
  // converter side
  input wire logic [14:0] conv_code,
  input wire logic        conv_valid,
  input wire logic [3:0]  fault_in,
  input wire logic [7:0]  config_value,
  input wire logic [7:0]  fault_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // long deselected stretch, no write can land
  sequence s_idle;
    chip_sel_n [*8];
  endsequence
  sequence s_flagged;
    fault_status != 8'h00;
  endsequence

  property p_cs_float;
    chip_sel_n |-> !serial_out_en;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("output enabled while deselected");
  property p_out_zero;
    !serial_out_en |-> !serial_out;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("output data while not driven");
  property p_rst_vals;
    $fell(reset) |-> config_value == 8'h00 && fault_status == 8'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("bad value after reset");
  property p_fault_in;
    |fault_in |=> (fault_status[5:2] & $past(fault_in)) == $past(fault_in);
  endproperty
  a_fault_in: assert property (p_fault_in)
    else $error("fault input not latched");
  property p_hold;
    s_idle ##0 s_flagged |=>
      (fault_status & $past(fault_status)) == $past(fault_status);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched flag dropped");
  property p_cfg_bit1;
    config_value[1] == 1'b0;
  endproperty
  a_cfg_bit1: assert property (p_cfg_bit1)
    else $error("clear bit reads set");
  property p_low_trip;
    conv_valid && conv_code == 15'h0000 |=> fault_status[6];
  endproperty
  a_low_trip: assert property (p_low_trip)
    else $error("low trip missed");
  property p_high_trip;
    conv_valid && conv_code == 15'h7fff |=> fault_status[7];
  endproperty
  a_high_trip: assert property (p_high_trip)
    else $error("high trip missed");
endmodule : rtdspi_top_props

bind rtdspi_top rtdspi_top_props i_props (
  .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk),
  .chip_sel_n(chip_sel_n), .serial_in(serial_in),
  .serial_out(serial_out), .serial_out_en(serial_out_en),
  .conv_code(conv_code), .conv_valid(conv_valid), .fault_in(fault_in),
  .config_value(config_value), .fault_status(fault_status)
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the serial register port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk    = 1'b0;
  logic        reset      = 1'b0;
  logic [14:0] conv_code  = 15'h0000;
  logic        conv_valid = 1'b0;
  logic [3:0]  fault_in   = 4'h0;
  wire         serial_clk, chip_sel_n, serial_in, serial_out, serial_out_en;
  wire  [7:0]  config_value, fault_status;
  int          n_errors    = 0;
  int          check_count = 0;
  logic [7:0]  rb [4];

  always #25 sys_clk = ~sys_clk;

  rtdspi_top i_dut (
    .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .conv_code(conv_code), .conv_valid(conv_valid), .fault_in(fault_in),
    .config_value(config_value), .fault_status(fault_status)
  );
  rtdspi_master i_mst (
    .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one frame: address byte then n data bytes
  task automatic xfer(input logic cpol, input logic [7:0] a, input int n,
                      input logic [7:0] d0 = 8'h00, d1 = 8'h00);
    logic [7:0] junk;
    i_mst.start(cpol);
    i_mst.xbyte(a, junk);
    for (int k = 0; k < n; k++)
      i_mst.xbyte(k ? d1 : d0, rb[k]);
    i_mst.stop();
  endtask : xfer

  // one conversion result pulse
  task automatic conv(input logic [14:0] c);
    @(posedge sys_clk) #2 conv_code = c;
    conv_valid = 1'b1;
    @(posedge sys_clk) #2 conv_valid = 1'b0;
    @(posedge sys_clk) #2;
  endtask : conv

  task automatic t_reset;
    xfer(1'b0, 8'h03, 4);
    check("upper hi", 8'hff, rb[0]);
    check("upper lo", 8'hff, rb[1]);
    check("lower hi", 8'h00, rb[2]);
    check("lower lo", 8'h00, rb[3]);
    xfer(1'b1, 8'h07, 2);
    check("flags", 8'h00, rb[0]);
    check("unmapped", 8'hff, rb[1]);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_trip;
    conv(15'h4000);
    xfer(1'b1, 8'h01, 2);
    check("data hi", 8'h80, rb[0]);
    check("data lo", 8'h00, rb[1]);
    xfer(1'b0, 8'h83, 2, 8'h40, 8'h00);
    conv(15'h2000);
    check("status", 8'h80, fault_status);
    conv(15'h1fff);
    check("status", 8'h80, fault_status);
    xfer(1'b0, 8'h01, 4);
    check("data hi", 8'h3f, rb[0]);
    check("data lo", 8'hff, rb[1]);
    check("upper hi", 8'h40, rb[2]);
    xfer(1'b1, 8'h85, 2, 8'h10, 8'h00);
    conv(15'h0800);
    check("status", 8'hc0, fault_status);
    $display("t_trip done");
  endtask : t_trip

  task automatic t_clear;
    xfer(1'b1, 8'h80, 1, 8'h06);
    check("status", 8'hc0, fault_status);
    check("config", 8'h04, config_value);
    xfer(1'b0, 8'h80, 1, 8'h02);
    check("status", 8'h00, fault_status);
    check("config", 8'h00, config_value);
    xfer(1'b0, 8'h81, 2, 8'h55, 8'haa);
    xfer(1'b1, 8'h01, 2);
    check("data hi", 8'h10, rb[0]);
    check("data lo", 8'h00, rb[1]);
    xfer(1'b0, 8'h7f, 2);
    check("wrap unmapped", 8'hff, rb[0]);
    check("wrap config", 8'h00, rb[1]);
    xfer(1'b1, 8'hff, 2, 8'h11, 8'h20);
    check("config", 8'h20, config_value);
    xfer(1'b0, 8'h80, 1, 8'h00);
    $display("t_clear done");
  endtask : t_clear

  task automatic t_faults;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) #2 fault_in = 4'h1 << k;
      @(posedge sys_clk) #2 fault_in = 4'h0;
      check("status", {2'b00, 4'((2 << k) - 1), 2'b00}, fault_status);
    end
    conv(15'h0000);
    conv(15'h7fff);
    check("status", 8'hfc, fault_status);
    repeat (10) @(posedge sys_clk);
    xfer(1'b1, 8'h02, 1);
    check("data lo", 8'hff, rb[0]);
    xfer(1'b0, 8'h80, 1, 8'h02);
    check("status", 8'h00, fault_status);
    $display("t_faults done");
  endtask : t_faults

  // main sequence
  initial begin
    // a real rising edge clears the link side asynchronously
    #2 reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2 reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_trip();
    t_clear();
    t_faults();
    end_sim();
  end

  // watchdog
  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
